// [logic/shc_defines.svh]
// constants for the spindle and head control sequencer
`ifndef SHC_DEFINES_SVH
`define SHC_DEFINES_SVH

// --------------------------------------------------------------
// clock rates in hertz and divider accumulator width
// --------------------------------------------------------------
`define SHC_F_CLK_HZ      40000000
`define SHC_F_CPU_HZ      9216000
`define SHC_F_MIX_HI_HZ   1152000
`define SHC_F_MIX_LO_HZ   576000
`define SHC_F_CHK_HZ      92100
`define SHC_F_SPIN_HZ     360
`define SHC_ACC_W         32

// --------------------------------------------------------------
// spindle speed figures
// --------------------------------------------------------------
`define SHC_RPM_NOM       3600
`define SHC_TOL_PCT       1
`define SHC_CNT_W         12
`define SHC_ERR_W         6

`endif

// [logic/shc_pkg.sv]
// types for the spindle and head control sequencer
package shc_pkg;

	// ----------------------------------------------------------
	// speed checker states
	// ----------------------------------------------------------
	typedef enum logic [1:0] {
		SHC_CHK_IDLE  = 2'b00,
		SHC_CHK_FIRST = 2'b01,
		SHC_CHK_RUN   = 2'b10
	} shc_chk_state_t;

endpackage : shc_pkg

// [logic/shc_sequencer.sv]
// spindle, clock and head control logic of the drive assembly
`timescale 1ns/10ps
`include "shc_defines.svh"

// Operation
// R1 - divide reference into cpu, two mixer, checker and spindle rates
// R2 - phase compare 360 Hz reference with hall edges to hold speed
// R3 - lookup table maps three hall inputs to one driven phase
// R4 - after reset controller releases halt, leaves regulation off
// R5 - controller engages regulation once marker interval within one percent
// R6 - halt goes to speed control and brake relay driver
// R7 - controller releases actuator lock only after speed reached
// R8 - count checker ticks per revolution, flag speed reached and pending
// R9 - controller shuts down when measured speed leaves range
// R10 - fourth hall makes one marker per turn, sent out active low
// R11 - a preamplifier is enabled only by its active low enable
// R12 - two bit head code picks one of four heads per chip
// R13 - direction high selects write, low selects read
// R14 - missing head swings in write mode raise a write fault
// R15 - write current during read mode also raises a write fault
// R16 - four heads per chip, one or two chips fitted
// R17 - status logic forms write gate, seek complete, fault, ready
// R18 - status built from reset, fault, gate, select, stop, seek, speed
// R19 - interval compared against fixed one percent thresholds
module shc_sequencer #(
	parameter int NUM_CHIPS = 2
) (
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic [2:0]           hall,
	input  wire logic                 hall_index,
	input  wire logic                 regulation_engage,
	input  wire logic                 stop_motor,
	input  wire logic                 lock_pick,
	input  wire logic [2:0]           head_sel,
	input  wire logic                 drive_sel,
	input  wire logic                 write_gate,
	input  wire logic                 seek_done,
	input  wire logic [NUM_CHIPS-1:0] head_fault_current,
	output logic                      cpu_clk_en,
	output logic                      mix_hi_en,
	output logic                      mix_lo_en,
	output logic                      chk_ref_en,
	output logic                      spin_ref_en,
	output logic [2:0]                phase_drive,
	output logic                      drive_boost,
	output logic                      brake_on,
	output logic                      lock_drive,
	output logic                      speed_reached,
	output logic                      count_pending,
	output logic                      rev_marker_out_n,
	output logic [NUM_CHIPS-1:0]      chip_en_n,
	output logic                      head_pick_bit0,
	output logic                      head_pick_bit1,
	output logic                      rw_direction,
	output logic                      write_gate_out,
	output logic                      seek_complete_out,
	output logic                      write_fault_out,
	output logic                      ready_out
);
	import shc_pkg::*;

	// ----------------------------------------------------------
	// derived constants
	// ----------------------------------------------------------
	localparam logic [63:0] ACC_ONE = 64'h1 << `SHC_ACC_W;
	localparam logic [`SHC_ACC_W-1:0] INC_CPU =
		`SHC_ACC_W'(ACC_ONE * `SHC_F_CPU_HZ / `SHC_F_CLK_HZ);
	localparam logic [`SHC_ACC_W-1:0] INC_HI =
		`SHC_ACC_W'(ACC_ONE * `SHC_F_MIX_HI_HZ / `SHC_F_CLK_HZ);
	localparam logic [`SHC_ACC_W-1:0] INC_LO =
		`SHC_ACC_W'(ACC_ONE * `SHC_F_MIX_LO_HZ / `SHC_F_CLK_HZ);
	localparam logic [`SHC_ACC_W-1:0] INC_CHK =
		`SHC_ACC_W'(ACC_ONE * `SHC_F_CHK_HZ / `SHC_F_CLK_HZ);
	localparam logic [`SHC_ACC_W-1:0] INC_SPIN =
		`SHC_ACC_W'(ACC_ONE * `SHC_F_SPIN_HZ / `SHC_F_CLK_HZ);
	localparam int REV_NOM = `SHC_F_CHK_HZ * 60 / `SHC_RPM_NOM;
	localparam logic [`SHC_CNT_W-1:0] REV_LO =
		`SHC_CNT_W'(REV_NOM * (100 - `SHC_TOL_PCT) / 100);
	localparam logic [`SHC_CNT_W-1:0] REV_HI =
		`SHC_CNT_W'(REV_NOM * (100 + `SHC_TOL_PCT) / 100);
	localparam logic [`SHC_CNT_W-1:0] CNT_MAX = '1;
	localparam int HSEL_W = (NUM_CHIPS > 1) ? 3 : 2;
	// a one-bit signed literal would sign-extend to minus one
	localparam logic signed [`SHC_ERR_W-1:0] ERR_ONE = `SHC_ERR_W'(1);

	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	// phase accumulator step: carry out is the enable pulse
	function automatic logic [`SHC_ACC_W:0] nco_step(
		input logic [`SHC_ACC_W-1:0] acc,
		input logic [`SHC_ACC_W-1:0] inc
	);
		nco_step = {1'b0, acc} + {1'b0, inc};
	endfunction : nco_step

	// one phase per valid hall pattern; 000 and 111 are sensor faults
	function automatic logic [2:0] commutate(input logic [2:0] h);
		case (h)
			3'h1:    commutate = 3'h1;
			3'h3:    commutate = 3'h2;
			3'h2:    commutate = 3'h2;
			3'h6:    commutate = 3'h4;
			3'h4:    commutate = 3'h4;
			3'h5:    commutate = 3'h1;
			default: commutate = 3'h0;
		endcase
	endfunction : commutate

	// ----------------------------------------------------------
	// clock generator
	// ----------------------------------------------------------
	// fractional dividers: rates are exact on average, jitter one cycle
	logic [`SHC_ACC_W-1:0] acc_cpu, acc_hi, acc_lo, acc_chk, acc_spin;
	logic [`SHC_ACC_W:0]   nx_cpu, nx_hi, nx_lo, nx_chk, nx_spin;

	assign nx_cpu  = nco_step(acc_cpu, INC_CPU);
	assign nx_hi   = nco_step(acc_hi, INC_HI);
	assign nx_lo   = nco_step(acc_lo, INC_LO);
	assign nx_chk  = nco_step(acc_chk, INC_CHK);
	assign nx_spin = nco_step(acc_spin, INC_SPIN);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{acc_cpu, acc_hi, acc_lo, acc_chk, acc_spin} <= '0;
			{cpu_clk_en, mix_hi_en, mix_lo_en} <= 3'h0;
			{chk_ref_en, spin_ref_en} <= 2'h0;
		end else begin
			acc_cpu     <= nx_cpu[`SHC_ACC_W-1:0];   // see R1
			acc_hi      <= nx_hi[`SHC_ACC_W-1:0];
			acc_lo      <= nx_lo[`SHC_ACC_W-1:0];
			acc_chk     <= nx_chk[`SHC_ACC_W-1:0];
			acc_spin    <= nx_spin[`SHC_ACC_W-1:0];
			cpu_clk_en  <= nx_cpu[`SHC_ACC_W];
			mix_hi_en   <= nx_hi[`SHC_ACC_W];
			mix_lo_en   <= nx_lo[`SHC_ACC_W];
			chk_ref_en  <= nx_chk[`SHC_ACC_W];
			spin_ref_en <= nx_spin[`SHC_ACC_W];
		end
	end

	// ----------------------------------------------------------
	// spindle commutation and regulation
	// ----------------------------------------------------------
	logic [2:0]                  hall_q;
	logic                        hall_edge;
	logic signed [`SHC_ERR_W-1:0] phase_err;
	logic signed [`SHC_ERR_W-1:0] next_phase_err;

	assign hall_edge = |(hall ^ hall_q);

	// reference tick counts up, hall edge counts down; saturates
	always_comb begin
		next_phase_err = phase_err;
		if (spin_ref_en && !hall_edge &&
		    phase_err != {1'b0, {(`SHC_ERR_W-1){1'b1}}})
			next_phase_err = phase_err + ERR_ONE;
		else if (hall_edge && !spin_ref_en &&
		         phase_err != {1'b1, {(`SHC_ERR_W-1){1'b0}}})
			next_phase_err = phase_err - ERR_ONE;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hall_q      <= 3'h0;
			phase_err   <= '0;
			phase_drive <= 3'h0;
			drive_boost <= 1'b0;
			brake_on    <= 1'b1;
		end else begin
			hall_q      <= hall;
			// free acceleration until the loop is engaged
			phase_err   <= regulation_engage ? next_phase_err : '0;
			phase_drive <= stop_motor ? 3'h0 : commutate(hall);  // see R3 R6
			drive_boost <= !stop_motor &&
			               (!regulation_engage || phase_err > 0); // see R2 R4
			brake_on    <= stop_motor;                           // see R6
		end
	end

	// ----------------------------------------------------------
	// revolution marker and speed checker
	// ----------------------------------------------------------
	logic                  index_q;
	logic                  rev_edge;
	logic [`SHC_CNT_W-1:0] rev_cnt;
	shc_chk_state_t        chk_state;

	assign rev_edge = hall_index && !index_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			index_q          <= 1'b0;
			rev_marker_out_n <= 1'b1;
		end else begin
			index_q          <= hall_index;
			rev_marker_out_n <= !hall_index;                    // see R10
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			chk_state     <= SHC_CHK_IDLE;
			rev_cnt       <= '0;
			speed_reached <= 1'b0;
			count_pending <= 1'b1;
		end else begin
			case (chk_state)
				SHC_CHK_IDLE: begin
					if (rev_edge) begin
						chk_state <= SHC_CHK_FIRST;
						rev_cnt   <= '0;
					end
				end
				SHC_CHK_FIRST, SHC_CHK_RUN: begin
					if (rev_edge) begin
						chk_state     <= SHC_CHK_RUN;
						rev_cnt       <= '0;
						count_pending <= 1'b0;                  // see R8
						speed_reached <= rev_cnt >= REV_LO &&
						                 rev_cnt <= REV_HI;     // see R8 R19
					end else if (chk_ref_en) begin
						if (rev_cnt != CNT_MAX)
							rev_cnt <= rev_cnt + 1'b1;
						// a stalled spindle never gives another marker
						if (rev_cnt >= REV_HI)
							speed_reached <= 1'b0;
					end
				end
				default: chk_state <= SHC_CHK_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------
	// head select, fault detector and status logic
	// ----------------------------------------------------------
	logic [HSEL_W-1:0] head_num;
	logic              unsafe_sel;

	assign head_num   = head_sel[HSEL_W-1:0];
	assign unsafe_sel = (NUM_CHIPS > 1) ?
		head_fault_current[head_num[HSEL_W-1]] : head_fault_current[0];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			chip_en_n      <= '1;
			head_pick_bit0 <= 1'b0;
			head_pick_bit1 <= 1'b0;
			rw_direction   <= 1'b0;
		end else begin
			for (int i = 0; i < NUM_CHIPS; i++)                 // see R16
				chip_en_n[i] <= !(drive_sel &&
				    (NUM_CHIPS == 1 || head_num[HSEL_W-1] == i[0])); // see R11
			head_pick_bit0 <= head_sel[0];                      // see R12
			head_pick_bit1 <= head_sel[1];
			rw_direction   <= drive_sel && write_gate;          // see R13
		end
	end

	// unsafe current in either mode is a fault; held until deselect
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			write_fault_out   <= 1'b0;
			write_gate_out    <= 1'b0;
			seek_complete_out <= 1'b0;
			ready_out         <= 1'b0;
			lock_drive        <= 1'b0;
		end else begin
			if (drive_sel && unsafe_sel)                         // see R14 R15
				write_fault_out <= 1'b1;
			else if (!drive_sel)
				write_fault_out <= 1'b0;
			write_gate_out    <= drive_sel && write_gate &&
			                     ready_out && !write_fault_out;  // see R17 R18
			seek_complete_out <= drive_sel && seek_done;
			ready_out         <= drive_sel && speed_reached &&
			                     !stop_motor && !write_fault_out;
			lock_drive        <= lock_pick;
		end
	end

	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence seq_index_rise;
		!hall_index ##1 hall_index;
	endsequence

	sequence seq_marker_low;
		!rev_marker_out_n;
	endsequence

	AST_CHK_RATE: assert property (                        // see R1
		chk_ref_en |=> !chk_ref_en [*8])
		else $error("checker reference enable too frequent");
	AST_SPIN_GAP: assert property (                        // see R1
		spin_ref_en |=> !spin_ref_en [*8] ##1 !spin_ref_en [*8])
		else $error("spindle reference enable too frequent");
	AST_COMMUTATE: assert property (                       // see R3
		(!stop_motor && hall == 3'h6) |=> phase_drive == 3'h4)
		else $error("commutation table wrong");
	AST_BOOST: assert property (                           // see R2
		(regulation_engage && !stop_motor && phase_err > 0)
		|=> drive_boost)
		else $error("regulator did not boost lagging spindle");
	AST_BRAKE: assert property (                           // see R6
		stop_motor |=> brake_on && phase_drive == 3'h0 && !drive_boost)
		else $error("halt did not brake and disable drive");
	AST_MARKER: assert property (                          // see R10
		seq_index_rise |=> seq_marker_low)
		else $error("marker not driven low");
	AST_REACHED: assert property (                         // see R8
		$rose(speed_reached) |-> $past(rev_edge) &&
		$past(rev_cnt) >= REV_LO && $past(rev_cnt) <= REV_HI)
		else $error("speed reached without in range period");
	AST_PENDING: assert property (                         // see R8
		$fell(count_pending) |-> $past(chk_state) != SHC_CHK_IDLE)
		else $error("pending cleared before a full period");
	AST_HEAD_PICK: assert property (                       // see R12
		##1 head_pick_bit1 == $past(head_sel[1]) &&
		head_pick_bit0 == $past(head_sel[0]))
		else $error("head code not forwarded");
	AST_RW_DIR: assert property (                          // see R13
		(drive_sel && write_gate) |=> rw_direction)
		else $error("write mode not selected");
	AST_ONE_CHIP: assert property (                        // see R11 R16
		$countones(~chip_en_n) <= 1)
		else $error("more than one preamplifier enabled");
	AST_WFAULT: assert property (                          // see R14 R15
		(drive_sel && unsafe_sel) |=> write_fault_out [*1] ##1
		(write_fault_out || !$past(drive_sel)))
		else $error("unsafe current not reported");
	AST_READY: assert property (                           // see R17 R18
		ready_out |-> $past(speed_reached && drive_sel && !stop_motor))
		else $error("ready without its conditions");

endmodule : shc_sequencer

// [tb/shc_ctrl_model.sv]
// controller model that sequences spin-up and supervises the speed checker
`timescale 1ns/10ps
module shc_ctrl_model (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic speed_reached,
	input  wire logic count_pending,
	output logic      regulation_engage,
	output logic      stop_motor,
	output logic      lock_pick
);
	// ----------------------------------------------------------
	// spin-up and supervision
	// ----------------------------------------------------------
	// moves on the falling edge so the sequencer samples settled levels
	always @(negedge clk or negedge rstn) begin
		if (!rstn) begin
			stop_motor        <= 1'b0;
			regulation_engage <= 1'b0;
			lock_pick         <= 1'b0;
		end else begin
			// halt latches: once out of range the drive stays down
			if (!count_pending && !speed_reached) begin
				stop_motor <= 1'b1;
			end
			regulation_engage <= speed_reached && !stop_motor;
			lock_pick         <= lock_pick || speed_reached;
		end
	end
endmodule : shc_ctrl_model

// [tb/tb.sv]
// self-checking bench for the spindle and head control sequencer
`timescale 1ns/10ps
module tb;
	logic       clk, rstn, hall_index, drive_sel, write_gate, seek_done;
	logic       regulation_engage, stop_motor, lock_pick;
	logic [2:0] hall, head_sel, phase_drive;
	logic [1:0] head_fault_current, chip_en_n;
	logic       cpu_clk_en, mix_hi_en, mix_lo_en, chk_ref_en, spin_ref_en;
	logic       drive_boost, brake_on, lock_drive, speed_reached;
	logic       count_pending, rev_marker_out_n, head_pick_bit0;
	logic       head_pick_bit1, rw_direction, write_gate_out;
	logic       seek_complete_out, write_fault_out, ready_out;
	int         bad_count, n_compared, n;
	int         cnt [5];

	shc_sequencer #(.NUM_CHIPS(2)) shc_sequencer_inst (
		.clk(clk), .rstn(rstn), .hall(hall), .hall_index(hall_index),
		.regulation_engage(regulation_engage), .stop_motor(stop_motor),
		.lock_pick(lock_pick), .head_sel(head_sel), .drive_sel(drive_sel),
		.write_gate(write_gate), .seek_done(seek_done),
		.head_fault_current(head_fault_current), .cpu_clk_en(cpu_clk_en),
		.mix_hi_en(mix_hi_en), .mix_lo_en(mix_lo_en),
		.chk_ref_en(chk_ref_en), .spin_ref_en(spin_ref_en),
		.phase_drive(phase_drive), .drive_boost(drive_boost),
		.brake_on(brake_on), .lock_drive(lock_drive),
		.speed_reached(speed_reached), .count_pending(count_pending),
		.rev_marker_out_n(rev_marker_out_n), .chip_en_n(chip_en_n),
		.head_pick_bit0(head_pick_bit0), .head_pick_bit1(head_pick_bit1),
		.rw_direction(rw_direction), .write_gate_out(write_gate_out),
		.seek_complete_out(seek_complete_out),
		.write_fault_out(write_fault_out), .ready_out(ready_out)
	);

	shc_ctrl_model shc_ctrl_model_inst (
		.clk(clk), .rstn(rstn), .speed_reached(speed_reached),
		.count_pending(count_pending),
		.regulation_engage(regulation_engage), .stop_motor(stop_motor),
		.lock_pick(lock_pick)
	);

	// ----------------------------------------------------------
	// clock, shared tasks
	// ----------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic tick(input int k);
		repeat (k) @(negedge clk);
	endtask : tick

	task automatic chk(input logic [3:0] seen, input logic [3:0] exp,
			input string what);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h",
				$time, what, seen, exp);
		end
	endtask : chk

	task automatic test_done;
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : test_done

	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		rstn = 1'b0;
		hall = 3'h6;
		hall_index = 1'b0;
		head_sel = 3'h0;
		drive_sel = 1'b0;
		write_gate = 1'b0;
		seek_done = 1'b0;
		head_fault_current = 2'h0;
		bad_count = 0;
		n_compared = 0;
		tick(12);
		chk(brake_on, 1'b1, "brake in reset");
		chk(count_pending, 1'b1, "pending in reset");
		chk(rev_marker_out_n, 1'b1, "marker idle");
		chk(chip_en_n, 2'h3, "chips off in reset");
		rstn = 1'b1;
		tick(2);
		// unregulated spin-up: hall 6 drives phase 2 hard
		chk(phase_drive, 3'h4, "phase for hall 6");
		chk(drive_boost, 1'b1, "boost unregulated");
		chk(brake_on, 1'b0, "brake off");
		for (int h = 0; h < 8; h++) begin
			hall = h[2:0];
			tick(1);
			if (h == 0 || h == 7)
				chk(phase_drive, 3'h0, "bad hall");
			else
				chk(phase_drive == 3'h1 || phase_drive == 3'h2 ||
					phase_drive == 3'h4, 1'b1, "one phase");
		end
		hall = 3'h6;
		// window long enough that cpu, mixer and checker counts are checked to within one pulse of jitter; spindle rate gives under one pulse
		cnt = '{default: 0};
		repeat (40000) begin
			tick(1);
			cnt[0] += cpu_clk_en;
			cnt[1] += mix_hi_en;
			cnt[2] += mix_lo_en;
			cnt[3] += chk_ref_en;
			cnt[4] += spin_ref_en;
		end
		chk(cnt[0] >= 9215 && cnt[0] <= 9217, 1'b1, "cpu rate");
		chk(cnt[1] >= 1151 && cnt[1] <= 1153, 1'b1, "mix hi");
		chk(cnt[2] >= 575 && cnt[2] <= 577, 1'b1, "mix lo");
		chk(cnt[3] >= 91 && cnt[3] <= 93, 1'b1, "checker rate");
		chk(cnt[4] <= 1, 1'b1, "spin rate");
		// head select across both chips
		drive_sel = 1'b1;
		for (int h = 0; h < 8; h++) begin
			head_sel = h[2:0];
			tick(1);
			chk(chip_en_n, h[2] ? 2'h1 : 2'h2, "chip enable");
			chk({head_pick_bit1, head_pick_bit0}, h[1:0], "head");
		end
		// write stays blocked while the drive is not ready
		write_gate = 1'b1;
		seek_done = 1'b1;
		tick(3);
		chk(ready_out, 1'b0, "not ready before speed");
		chk(write_gate_out, 1'b0, "gate blocked");
		chk(seek_complete_out, 1'b1, "seek complete");
		chk(rw_direction, 1'b1, "write mode");
		write_gate = 1'b0;
		// unsafe current only counts on the selected chip
		head_sel = 3'h5;
		head_fault_current = 2'h1;
		tick(2);
		chk(write_fault_out, 1'b0, "unselected unsafe");
		chk(rw_direction, 1'b0, "read mode");
		head_fault_current = 2'h2;
		tick(1);
		chk(write_fault_out, 1'b1, "fault set");
		tick(1);
		chk(ready_out, 1'b0, "not ready on fault");
		head_fault_current = 2'h0;
		tick(3);
		chk(write_fault_out, 1'b1, "fault held");
		drive_sel = 1'b0;
		tick(2);
		chk(write_fault_out, 1'b0, "fault cleared");
		chk(chip_en_n, 2'h3, "deselected");
		chk(seek_complete_out, 1'b0, "seek gated off");
		// revolution far too short: result out of range, controller halts
		hall_index = 1'b1;
		tick(1);
		chk(rev_marker_out_n, 1'b0, "marker out");
		hall_index = 1'b0;
		tick(1);
		chk(count_pending, 1'b1, "first marker only arms");
		chk(rev_marker_out_n, 1'b1, "marker released");
		n = 0;
		for (int i = 0; i < 10000 && n < 10; i++) begin
			tick(1);
			if (chk_ref_en === 1'b1)
				n++;
		end
		chk(n == 10, 1'b1, "checker ticks seen");
		hall_index = 1'b1;
		tick(1);
		hall_index = 1'b0;
		tick(1);
		chk(count_pending, 1'b0, "measured");
		chk(speed_reached, 1'b0, "too fast");
		tick(2);
		chk(brake_on, 1'b1, "halted");
		chk(phase_drive, 3'h0, "no drive halted");
		chk(drive_boost, 1'b0, "no boost halted");
		chk(lock_drive, 1'b0, "lock held");
		test_done();
	end
endmodule : tb
